// [inc/prmc_pkg.sv]
package prmc_pkg;

  // Supply configuration as identified at cold boot
  typedef enum logic [1:0] {
    CFG_UNKNOWN = 2'h0,
    CFG_BUCK = 2'h1,
    CFG_BOOST = 2'h2
  } prmc_cfg_type;

  // Power mode of the system
  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'h0,
    MODE_SLEEP = 2'h1,
    MODE_HIBERNATE = 2'h2
  } prmc_mode_type;

  // Rail-link switch selection
  localparam logic [1:0] LINK_DIODE = 2'h0;
  localparam logic [1:0] LINK_HIBERN = 2'h1;
  localparam logic [1:0] LINK_SOFT = 2'h2;
  localparam logic [1:0] LINK_HARD = 2'h3;

  // Converter output level codes (boost high rail)
  localparam logic [1:0] LEVEL_1V8 = 2'h0;
  localparam logic [1:0] LEVEL_2V5 = 2'h1;
  localparam logic [1:0] LEVEL_3V0 = 2'h2;

  // Reset values
  localparam logic [1:0] LINK_RESET = LINK_DIODE;
  localparam logic [3:0] TRIM_RESET = 4'h0;
  localparam logic [1:0] LOWREG_RESET = 2'h0;
  localparam logic [1:0] LEVEL_RESET = LEVEL_1V8;

  // Software control fields
  typedef struct packed {
    logic clampAutoselectOff;
    logic [3:0] clampLevelTrim;
    logic coreRegRetentionOn;
    logic forceSlowclkCoreRetention;
    logic converterSleepOn;
    logic [1:0] lowRailRegulatorCtrl;
    logic [1:0] converterOutputLevel;
    logic converterOn;
    logic converterKeepInSleep;
    logic [1:0] railLinkSwitchCtrl;
    logic highRailCompareOn;
    logic railClampMode;
    logic highRailPorMask;
    logic highRailPorOff;
  } prmc_ctrl_type;

  // Drives toward the analog rails
  typedef struct packed {
    logic clampFromHighRail;
    logic railLinkClosed;
    logic railClampOn;
    logic converterRun;
    logic [1:0] converterLevel;
    logic highCompareOn;
  } prmc_rail_type;

endpackage

// [logic/prmc_sync.sv]
module prmc_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clkEn,
  // Data
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_q;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      syncOut <= 1'b0;
    end else if (clkEn) begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule // prmc_sync

// [logic/prmc_conv_ctrl.sv]
module prmc_conv_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clkEn,
  // Control
  input wire prmc_pkg::prmc_cfg_type cfg,
  input wire logic converterOn,
  input wire logic converterKeepInSleep,
  input wire logic sleepEntry,
  input wire logic wakeEvent,
  input wire logic asleep,
  // Status
  output logic convRun
);
  logic armed_q;
  logic hold_q;

  // Converter enable latched at sleep entry
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      armed_q <= 1'b0;
    end else if (clkEn && sleepEntry) begin
      armed_q <= converterOn;
    end
  end

  // Buck converter kept alive through sleep
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hold_q <= 1'b0;
    end else if (clkEn && sleepEntry) begin
      hold_q <= converterOn && converterKeepInSleep && cfg == prmc_pkg::CFG_BUCK;
    end
  end

  // Run only on software request; during sleep only if held
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      convRun <= 1'b0;
    end else if (clkEn) begin
      if (asleep && !wakeEvent) begin
        convRun <= hold_q;
      end else if (wakeEvent) begin
        convRun <= armed_q && converterOn;
      end else begin
        convRun <= converterOn;
      end
    end
  end

  a_wake_restart: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && wakeEvent && !armed_q |=> !convRun)
    else $error("converter restarted without enable at sleep entry");
  a_sleep_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && asleep && !wakeEvent && !hold_q |=> !convRun)
    else $error("converter running in sleep without keep");
endmodule // prmc_conv_ctrl

// [logic/prmc_power_rail_ctrl.sv]
// Notes on behaviour
// - Hibernation clamp uses higher rail; autoselect-off forces high rail.
// - Boost hibernation link code 1 closes the resistive link.
// - Link selection resets to diode-only option.
// - Link code 2 connects rails through resistor for whole sleep.
// - Link code 3 connects rails when high rail reaches low level.
// - Boost active high rail 1.8 V default, else 2.5 or 3.0 V.
// - Masked high-rail POR keeps status, no reset; off drops both.
// - Shorted rails (bypass) are identified as boost.
// - Boost: no converter start at cold boot; restart on wake if enabled.
// - Buck converter starts by software; runs in sleep only if kept.
// - Idle converter restarted in the wake cycle only if enabled at sleep entry; afterwards it follows converterOn.
module prmc_power_rail_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clkEn,
  // Software control fields
  input wire prmc_pkg::prmc_ctrl_type ctrl,
  // Power mode requests from the power FSM
  input wire prmc_pkg::prmc_mode_type modeReq,
  input wire logic sleepEntry,
  input wire logic wakeEvent,
  // Analog status pins
  input wire logic highRailAboveLow,
  input wire logic lowRailPresent,
  input wire logic highRailNearLow,
  input wire logic highRailPorRaw,
  // Rail drives
  output prmc_pkg::prmc_rail_type rail,
  output logic [3:0] clampTrim,
  output logic [1:0] lowRegCtrl,
  output logic coreRetention,
  output logic slowclkRetention,
  output logic converterSleepMode,
  // Status and reset
  output prmc_pkg::prmc_cfg_type supplyCfg,
  output logic highRailPorStatus,
  output logic highRailPorReset
);
  logic aboveSync;
  logic lowSync;
  logic nearSync;
  logic porSync;
  logic cfgDone_q;
  logic [1:0] cfgSettle_q;
  logic asleep;
  logic hibernating;
  logic convRun;
  prmc_pkg::prmc_mode_type mode_q;
  logic [1:0] linkSel_q;
  logic linkClosed_d;
  logic clampHigh_d;

  // Pin synchronisers
  prmc_sync uSyncAbove (
    .core_clk(core_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .asyncIn(highRailAboveLow),
    .syncOut(aboveSync)
  );
  prmc_sync uSyncLow (
    .core_clk(core_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .asyncIn(lowRailPresent),
    .syncOut(lowSync)
  );
  prmc_sync uSyncNear (
    .core_clk(core_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .asyncIn(highRailNearLow),
    .syncOut(nearSync)
  );
  prmc_sync uSyncPor (
    .core_clk(core_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .asyncIn(highRailPorRaw),
    .syncOut(porSync)
  );

  // Supply configuration detected once after reset, then kept
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      supplyCfg <= prmc_pkg::CFG_UNKNOWN;
      cfgDone_q <= 1'b0;
      cfgSettle_q <= 2'h0;
    end else if (clkEn) begin
      // Wait until the synchroniser holds the pin, it is cleared by reset
      cfgSettle_q <= {cfgSettle_q[0], 1'b1};
      if (cfgSettle_q[1] && !cfgDone_q) begin
        cfgDone_q <= 1'b1;
        // Low rail powered (boost or shorted bypass) reads as boost
        supplyCfg <= lowSync ? prmc_pkg::CFG_BOOST : prmc_pkg::CFG_BUCK;
      end
    end
  end

  // Power mode tracking
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mode_q <= prmc_pkg::MODE_ACTIVE;
    end else if (clkEn) begin
      if (wakeEvent) begin
        mode_q <= prmc_pkg::MODE_ACTIVE;
      end else if (sleepEntry) begin
        mode_q <= modeReq;
      end
    end
  end

  assign asleep = mode_q != prmc_pkg::MODE_ACTIVE;
  assign hibernating = mode_q == prmc_pkg::MODE_HIBERNATE;

  // Link selection sampled from software, diode option after reset
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      linkSel_q <= prmc_pkg::LINK_RESET;
    end else if (clkEn) begin
      linkSel_q <= ctrl.railLinkSwitchCtrl;
    end
  end

  // Rail link decision
  always_comb begin
    linkClosed_d = 1'b0;
    case (linkSel_q)
      prmc_pkg::LINK_DIODE: linkClosed_d = 1'b0;
      prmc_pkg::LINK_HIBERN: linkClosed_d = hibernating;
      prmc_pkg::LINK_SOFT: linkClosed_d = asleep;
      prmc_pkg::LINK_HARD: linkClosed_d = asleep && ctrl.highRailCompareOn && nearSync;
      default: linkClosed_d = 1'b0;
    endcase
    if (supplyCfg != prmc_pkg::CFG_BOOST) begin
      linkClosed_d = 1'b0;
    end
  end

  // Clamp supply choice
  always_comb begin
    clampHigh_d = 1'b1;
    if (!ctrl.clampAutoselectOff) begin
      clampHigh_d = aboveSync;
    end
  end

  // Converter sequencing across sleep
  prmc_conv_ctrl uConv (
    .core_clk(core_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .cfg(supplyCfg),
    .converterOn(ctrl.converterOn),
    .converterKeepInSleep(ctrl.converterKeepInSleep),
    .sleepEntry(sleepEntry),
    .wakeEvent(wakeEvent),
    .asleep(asleep),
    .convRun(convRun));

  // Registered rail drives
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rail <= '0;
    end else if (clkEn) begin
      rail.clampFromHighRail <= clampHigh_d;
      rail.railLinkClosed <= linkClosed_d;
      rail.railClampOn <= ctrl.railClampMode && !asleep;
      rail.converterRun <= convRun && !hibernating;
      rail.converterLevel <= ctrl.converterOutputLevel;
      rail.highCompareOn <= ctrl.highRailCompareOn && linkSel_q == prmc_pkg::LINK_HARD;
    end
  end

  // Retention and regulator settings passed to the analog side
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      clampTrim <= prmc_pkg::TRIM_RESET;
      lowRegCtrl <= prmc_pkg::LOWREG_RESET;
      coreRetention <= 1'b0;
      slowclkRetention <= 1'b0;
      converterSleepMode <= 1'b0;
    end else if (clkEn) begin
      clampTrim <= ctrl.clampLevelTrim;
      lowRegCtrl <= ctrl.lowRailRegulatorCtrl;
      coreRetention <= ctrl.coreRegRetentionOn;
      slowclkRetention <= ctrl.forceSlowclkCoreRetention;
      converterSleepMode <= ctrl.converterSleepOn;
    end
  end

  // High-rail power-on reset gating
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      highRailPorStatus <= 1'b0;
      highRailPorReset <= 1'b0;
    end else if (clkEn) begin
      highRailPorStatus <= porSync && !ctrl.highRailPorOff;
      highRailPorReset <= porSync && !ctrl.highRailPorOff && !ctrl.highRailPorMask;
    end
  end

  // Power-on reset checks
  a_por_masked: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && (ctrl.highRailPorMask || ctrl.highRailPorOff) |=> !highRailPorReset)
    else $error("masked high-rail reset asserted");
  a_por_off: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && ctrl.highRailPorOff |=> !highRailPorStatus)
    else $error("disabled high-rail status visible");
  a_por_status: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && !ctrl.highRailPorOff |=> highRailPorStatus == $past(porSync))
    else $error("high-rail status does not follow the pin");

  // Supply identification checks
  a_cfg_boost: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && cfgSettle_q[1] && !cfgDone_q && lowSync |=> supplyCfg == prmc_pkg::CFG_BOOST)
    else $error("powered low rail not identified as boost");
  a_cfg_kept: assert property (@(posedge core_clk) disable iff (!rstn)
    cfgDone_q |=> $stable(supplyCfg))
    else $error("supply configuration changed after detection");

  // Rail link checks
  a_link_reset: assert property (@(posedge core_clk)
    !rstn |=> linkSel_q == prmc_pkg::LINK_DIODE)
    else $error("link selection not diode after reset");
  a_link_diode: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && linkSel_q == prmc_pkg::LINK_DIODE |=> !rail.railLinkClosed)
    else $error("link closed with diode option");
  a_link_buck: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && supplyCfg != prmc_pkg::CFG_BOOST |=> !rail.railLinkClosed)
    else $error("link closed outside boost");
  a_link_awake: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && !asleep |=> !rail.railLinkClosed)
    else $error("link closed while active");
  a_link_soft: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && supplyCfg == prmc_pkg::CFG_BOOST && linkSel_q == prmc_pkg::LINK_SOFT
    && asleep |=> rail.railLinkClosed)
    else $error("soft link not closed in sleep");
  a_link_hib: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && supplyCfg == prmc_pkg::CFG_BOOST && linkSel_q == prmc_pkg::LINK_HIBERN
    && hibernating |=> rail.railLinkClosed)
    else $error("link not closed in boost hibernation");
  a_link_hib_only: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && linkSel_q == prmc_pkg::LINK_HIBERN && !hibernating |=> !rail.railLinkClosed)
    else $error("hibernation link closed outside hibernation");
  a_link_hard: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && linkSel_q == prmc_pkg::LINK_HARD && !nearSync |=> !rail.railLinkClosed)
    else $error("hardware link closed before rails meet");
  a_hard_close: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && supplyCfg == prmc_pkg::CFG_BOOST && linkSel_q == prmc_pkg::LINK_HARD
    && asleep && ctrl.highRailCompareOn && nearSync |=> rail.railLinkClosed)
    else $error("hardware link not closed when rails meet");
  a_compare_gate: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && linkSel_q != prmc_pkg::LINK_HARD |=> !rail.highCompareOn)
    else $error("comparator on without hardware link");

  // Clamp checks
  a_clamp_force: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && ctrl.clampAutoselectOff |=> rail.clampFromHighRail)
    else $error("clamp not forced to high rail");
  a_clamp_auto: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && !ctrl.clampAutoselectOff |=> rail.clampFromHighRail == $past(aboveSync))
    else $error("clamp not on the higher rail");
  a_clamp_mode: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && !asleep |=> rail.railClampOn == $past(ctrl.railClampMode))
    else $error("rail clamp does not follow its mode");
  a_clamp_asleep: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && asleep |=> !rail.railClampOn)
    else $error("rail clamp on during sleep");

  // Converter checks
  sequence s_boost_entry;
    clkEn && sleepEntry && !wakeEvent && supplyCfg == prmc_pkg::CFG_BOOST;
  endsequence
  sequence s_buck_keep_entry;
    clkEn && sleepEntry && !wakeEvent && supplyCfg == prmc_pkg::CFG_BUCK
      && ctrl.converterOn && ctrl.converterKeepInSleep;
  endsequence
  sequence s_sleep_step;
    clkEn && asleep && !wakeEvent;
  endsequence
  a_level_follow: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn |=> rail.converterLevel == $past(ctrl.converterOutputLevel))
    else $error("converter level not applied");
  a_conv_hib: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && hibernating |=> !rail.converterRun)
    else $error("converter running in hibernation");
  a_conv_active: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && !asleep && !wakeEvent |=> convRun == $past(ctrl.converterOn))
    else $error("converter does not follow software enable");
  a_boost_sleep_off: assert property (@(posedge core_clk) disable iff (!rstn)
    s_boost_entry ##1 s_sleep_step |=> !convRun)
    else $error("boost converter kept running in sleep");
  a_buck_sleep_keep: assert property (@(posedge core_clk) disable iff (!rstn)
    s_buck_keep_entry ##1 s_sleep_step |=> convRun)
    else $error("kept buck converter stopped in sleep");
endmodule // prmc_power_rail_ctrl

// [verification/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHECK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); \
    end \
  end
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic clkEn = 1'b1;
  prmc_pkg::prmc_ctrl_type ctrl = '0;
  prmc_pkg::prmc_mode_type modeReq = prmc_pkg::MODE_ACTIVE;
  logic sleepEntry = 1'b0;
  logic wakeEvent = 1'b0;
  logic highRailAboveLow = 1'b1;
  logic lowRailPresent = 1'b1;
  logic highRailNearLow = 1'b0;
  logic highRailPorRaw = 1'b0;
  prmc_pkg::prmc_rail_type rail;
  logic [3:0] clampTrim;
  logic [1:0] lowRegCtrl;
  logic coreRetention, slowclkRetention, converterSleepMode;
  prmc_pkg::prmc_cfg_type supplyCfg;
  logic highRailPorStatus, highRailPorReset;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic hardCompare;
  // Control word, raw pin, expected status, expected reset
  logic [22:0] actRows [7] = '{{20'h7E000, 3'b111}, {20'h01402, 3'b110}, {20'h00C39, 3'b100},
    {20'h00080, 3'b000}, {20'h00106, 3'b110}, {20'hC8200, 3'b111}, {20'h70400, 3'b000}};
  // Link code, mode, near pin, expected link
  logic [5:0] linkRows [6] = '{6'h06, 6'h14, 6'h19, 6'h25, 6'h34, 6'h37};
  prmc_power_rail_ctrl dut_u (.core_clk(core_clk), .rstn(rstn), .clkEn(clkEn), .ctrl(ctrl),
    .modeReq(modeReq), .sleepEntry(sleepEntry), .wakeEvent(wakeEvent),
    .highRailAboveLow(highRailAboveLow), .lowRailPresent(lowRailPresent),
    .highRailNearLow(highRailNearLow), .highRailPorRaw(highRailPorRaw), .rail(rail),
    .clampTrim(clampTrim), .lowRegCtrl(lowRegCtrl), .coreRetention(coreRetention),
    .slowclkRetention(slowclkRetention), .converterSleepMode(converterSleepMode),
    .supplyCfg(supplyCfg), .highRailPorStatus(highRailPorStatus),
    .highRailPorReset(highRailPorReset));
  always #2 core_clk = ~core_clk;
  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic enter(prmc_pkg::prmc_mode_type m);
    modeReq = m;
    sleepEntry = 1'b1;
    step(1);
    sleepEntry = 1'b0;
    step(5);
  endtask
  task automatic wake();
    modeReq = prmc_pkg::MODE_ACTIVE;
    wakeEvent = 1'b1;
    step(1);
    wakeEvent = 1'b0;
    step(5);
  endtask
  task automatic reset_dut(logic lp);
    rstn = 1'b0;
    ctrl = '0;
    lowRailPresent = lp;
    step(3);
    rstn = 1'b1;
    step(4);
  endtask
  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    reset_dut(1'b1);
    `CHECK(supplyCfg, prmc_pkg::CFG_BOOST)
    `CHECK(rail.railLinkClosed, 1'b0)
    `CHECK(rail.converterRun, 1'b0)
    $display("reset test done");
    foreach (actRows[i]) begin
      ctrl = actRows[i][22:3];
      highRailPorRaw = actRows[i][2];
      step(5);
      `CHECK(clampTrim, ctrl.clampLevelTrim)
      `CHECK(coreRetention, ctrl.coreRegRetentionOn)
      `CHECK(slowclkRetention, ctrl.forceSlowclkCoreRetention)
      `CHECK(converterSleepMode, ctrl.converterSleepOn)
      `CHECK(lowRegCtrl, ctrl.lowRailRegulatorCtrl)
      `CHECK(rail.converterLevel, ctrl.converterOutputLevel)
      `CHECK(rail.converterRun, ctrl.converterOn)
      `CHECK(rail.railClampOn, ctrl.railClampMode)
      hardCompare = ctrl.highRailCompareOn && ctrl.railLinkSwitchCtrl == prmc_pkg::LINK_HARD;
      `CHECK(rail.highCompareOn, hardCompare)
      `CHECK(highRailPorStatus, actRows[i][1])
      `CHECK(highRailPorReset, actRows[i][0])
    end
    $display("control row test done");
    foreach (linkRows[i]) begin
      ctrl = '0;
      ctrl.highRailCompareOn = 1'b1;
      ctrl.railLinkSwitchCtrl = linkRows[i][5:4];
      highRailNearLow = linkRows[i][1];
      step(5);
      enter(prmc_pkg::prmc_mode_type'(linkRows[i][3:2]));
      `CHECK(rail.railLinkClosed, linkRows[i][0])
      wake();
      `CHECK(rail.railLinkClosed, 1'b0)
    end
    $display("rail link test done");
    highRailAboveLow = 1'b1;
    enter(prmc_pkg::MODE_HIBERNATE);
    `CHECK(rail.clampFromHighRail, 1'b1)
    highRailAboveLow = 1'b0;
    step(5);
    `CHECK(rail.clampFromHighRail, 1'b0)
    ctrl.clampAutoselectOff = 1'b1;
    step(5);
    `CHECK(rail.clampFromHighRail, 1'b1)
    wake();
    $display("clamp test done");
    ctrl = '0;
    ctrl.converterOn = 1'b1;
    step(5);
    enter(prmc_pkg::MODE_SLEEP);
    `CHECK(rail.converterRun, 1'b0)
    wake();
    `CHECK(rail.converterRun, 1'b1)
    ctrl.converterOn = 1'b0;
    step(5);
    enter(prmc_pkg::MODE_SLEEP);
    wake();
    `CHECK(rail.converterRun, 1'b0)
    ctrl.converterOn = 1'b1;
    step(5);
    `CHECK(rail.converterRun, 1'b1)
    clkEn = 1'b0;
    ctrl.clampLevelTrim = 4'hA;
    step(4);
    `CHECK(clampTrim, 4'h0)
    clkEn = 1'b1;
    $display("boost converter test done");
    reset_dut(1'b0);
    `CHECK(supplyCfg, prmc_pkg::CFG_BUCK)
    `CHECK(rail.converterRun, 1'b0)
    ctrl.converterOn = 1'b1;
    ctrl.converterKeepInSleep = 1'b1;
    ctrl.railLinkSwitchCtrl = prmc_pkg::LINK_SOFT;
    step(5);
    enter(prmc_pkg::MODE_SLEEP);
    `CHECK(rail.converterRun, 1'b1)
    `CHECK(rail.railLinkClosed, 1'b0)
    wake();
    ctrl.converterKeepInSleep = 1'b0;
    step(5);
    enter(prmc_pkg::MODE_SLEEP);
    `CHECK(rail.converterRun, 1'b0)
    wake();
    `CHECK(rail.converterRun, 1'b1)
    $display("buck converter test done");
    finish_test();
  end
endmodule // testbench
